/* ppr_pkg.sv */
/*
 Constants, state types and field layout shared by both ends of the pack
 protection register bank link. Assumes a single 20 MHz core clock per end.
*/
// Summary of operation
// R1 - Written ones act; status ones mean present.
// R2 - Host writes reserved bits as zero.
// R3 - Host never writes addresses 09H to FFH.
// R4 - Host ignores reserved bits on reads.
// R5 - Reading fault status clears gone conditions.
// R6 - Other status follows its condition live.
// R7 - Forced sleep is zero after power-up.
// R8 - Active wake pin edge clears forced sleep.
// R9 - Writing zero clears forced sleep.
// R10 - Automatic trips clear both switch enables.
// R11 - Written switch enables drive the switches.
// R12 - Switch enable reads return drive state.
// R13 - Upper device reads unimplemented status zero.
// R14 - Upper device stores unused settings harmlessly.
// R15 - Host writes zeros to unused upper registers.
// R16 - Discharge settings need their write guard.
// R17 - Charge settings need their write guard.
// R18 - Feature settings need their write guard.
// R19 - Charge time divider divides by 32.
// R20 - Discharge time divider divides by 64.
// R21 - Scan-off bit stops external temperature scan.
// R22 - Thermal shutdown disable bits, external and internal.
// R23 - Wake status is pin compare, polarity adjusted.
// R24 - Writable registers reset to zero.
package ppr_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PACK_CONFIG_STATUS = 8'h00;
   localparam logic [7:0] ADDR_FAULT_EVENT_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CELL_EQUALIZE_CTRL = 8'h02;
   localparam logic [7:0] ADDR_MONITOR_SELECT_FLAGS = 8'h03;
   localparam logic [7:0] ADDR_SWITCH_DRIVE_CTRL = 8'h04;
   localparam logic [7:0] ADDR_DISCHARGE_PROTECT_CFG = 8'h05;
   localparam logic [7:0] ADDR_CHARGE_PROTECT_CFG = 8'h06;
   localparam logic [7:0] ADDR_FEATURE_OPTIONS = 8'h07;
   localparam logic [7:0] ADDR_WRITE_GUARD_FLAGS = 8'h08;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int UPPER_CASCADE_FLAG = 7;
   localparam int LOWER_CASCADE_FLAG = 6;
   localparam int WAKE_PIN_STATE = 4;
   localparam int EXTERNAL_OVERTEMP_FLAG = 5;
   localparam int INTERNAL_OVERTEMP_FLAG = 4;
   localparam int LOAD_FAULT_FLAG = 3;
   localparam int DISCHARGE_SHORT_FLAG = 2;
   localparam int DISCHARGE_OVERCURRENT_FLAG = 1;
   localparam int CHARGE_OVERCURRENT_FLAG = 0;
   localparam logic [5:0] UPPER_FAULT_MASK = 6'h10;
   localparam logic [5:0] LOWER_FAULT_MASK = 6'h3f;
   localparam int FORCE_SLEEP = 7;
   localparam int MONITOR_CONNECT = 6;
   localparam int CHARGE_SWITCH_ENABLE = 1;
   localparam int DISCHARGE_SWITCH_ENABLE = 0;
   localparam int AUTO_DISCHARGE_OC_OFF = 7;
   localparam int AUTO_SHORT_OFF = 4;
   localparam int AUTO_CHARGE_OC_OFF = 7;
   localparam int CHARGE_TIME_DIV32 = 3;
   localparam int DISCHARGE_TIME_DIV64 = 2;
   localparam int TIMEOUT_SEL_LSB = 0;
   localparam int EXT_TEMP_SCAN_OFF = 7;
   localparam int EXT_THERMAL_SHUTDOWN_OFF = 4;
   localparam int INT_THERMAL_SHUTDOWN_OFF = 3;
   localparam int FORCE_RESET = 2;
   localparam int WAKE_PIN_OFF = 1;
   localparam int WAKE_POLARITY = 0;
   localparam int FEATURE_CFG_WRITE_ENABLE = 7;
   localparam int CHARGE_CFG_WRITE_ENABLE = 6;
   localparam int DISCHARGE_CFG_WRITE_ENABLE = 5;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int DIV32_SHIFT = 5;
   localparam int DIV64_SHIFT = 6;
   localparam logic [15:0] TIMEOUT_BASE_CYC = 16'h0400;
   localparam logic [7:0] LINK_HALF_CYC = 8'h08;
   localparam logic [4:0] HEAD_BITS = 5'h09;
   localparam logic [4:0] FRAME_BITS = 5'h11;

   // ------------------------------------------------------------------
   // Controller registers on the system bus
   // ------------------------------------------------------------------
   localparam logic [7:0] HOST_CMD_OFS = 8'h00;
   localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
   localparam int CMD_READ_BIT = 16;
   localparam int STATUS_BUSY_BIT = 8;

   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_HEAD = 2'h1,
      DEV_BODY = 2'h3
   } ppr_dev_state_type;

   typedef enum logic [2:0] {
      HOST_IDLE = 3'h0,
      HOST_START = 3'h1,
      HOST_LOW = 3'h3,
      HOST_HIGH = 3'h2,
      HOST_STOP = 3'h6
   } ppr_host_state_type;

endpackage

/* ppr_link_if.sv */
/*
 Two-wire link between controller and register bank.
 Assumes the data wire is pulled high and resolves as a wired AND.
*/
interface ppr_link_if;
   logic link_clk;
   logic host_dat_o;
   logic host_dat_oe_n;
   logic dev_dat_o;
   logic dev_dat_oe_n;
   logic dat;

   // ------------------------------------------------------------------
   // Wire resolution
   // ------------------------------------------------------------------
   assign dat = (host_dat_oe_n | host_dat_o) & (dev_dat_oe_n | dev_dat_o);

   modport host (output link_clk, output host_dat_o, output host_dat_oe_n, input dat);
   modport device (input link_clk, input dat, output dev_dat_o, output dev_dat_oe_n);
endinterface

/* ppr_sync.sv */
/*
 Two flip-flop synchroniser for a group of levels.
 Assumes the inputs come from outside the core clock domain.
*/
module ppr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } ppr_sync_state_type;

   ppr_sync_state_type q;
   ppr_sync_state_type d;

   always_comb begin
      d.meta = async_in;
      d.stable = q.meta;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.stable;
endmodule // ppr_sync

/* ppr_device.sv */
/*
 Register bank end: serial frame receiver, register store, fault flags,
 overcurrent time-outs and switch drive. Assumes the controller makes
 the link clock and that sensed conditions arrive as asynchronous levels.
*/
module ppr_device #(
   parameter bit UPPER = 1'b0,
   parameter logic [15:0] TIMEOUT_BASE = ppr_pkg::TIMEOUT_BASE_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Link
   ppr_link_if.device link,
   // Sensed conditions
   input wire logic wake_cmp,
   input wire logic ext_hot,
   input wire logic int_hot,
   input wire logic load_heavy,
   input wire logic short_cond,
   input wire logic dis_oc_cond,
   input wire logic chg_oc_cond,
   // Drive outputs
   output logic charge_drive,
   output logic discharge_drive,
   output logic sleep_req,
   output logic monitor_connect,
   output logic [6:0] cell_equalize,
   output logic [3:0] monitor_select,
   output logic ext_temp_scan_off
);
   typedef struct packed {
      ppr_pkg::ppr_dev_state_type st;
      logic [4:0] cnt;
      logic [16:0] sh;
      logic rdm;
      logic [7:0] rd;
      logic dat_o;
      logic dat_oe_n;
      logic clk_p;
      logic dat_p;
      logic wake_p;
      logic sc_p;
      logic [15:0] dtmr;
      logic [15:0] ctmr;
      logic [5:0] flags;
      logic [8:2][7:0] regs;
   } ppr_dev_state_type_q_type;

   ppr_dev_state_type_q_type q;
   ppr_dev_state_type_q_type d;
   logic [8:0] s;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   ppr_sync #(.WIDTH(9)) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in({link.link_clk, link.dat, wake_cmp, ext_hot, int_hot, load_heavy,
                 short_cond, dis_oc_cond, chg_oc_cond}),
      .sync_out(s)
   );

   function automatic logic [15:0] tmo_limit(input logic [1:0] sel, input logic div,
                                             input int sh);
      logic [15:0] t;
      t = TIMEOUT_BASE << sel;
      if (div) begin
         t = t >> sh;
      end
      if (t == 16'h0000) begin
         t = 16'h0001;
      end
      return t;
   endfunction

   logic s_clk, s_dat, wake_lvl, ext_g, s_int, s_sc, s_doc, s_coc, s_load;
   logic clk_rise, clk_fall, wr_en, rd_clr, force_rst, doc_trip, coc_trip, sc_trip, kill;
   logic [16:0] nsh;
   logic [7:0] wa, wd, rbyte;
   logic [15:0] dlim, clim;
   logic [5:0] fmask, fset, fcond;

   always_comb begin
      d = q;
      s_clk = s[8];
      s_dat = s[7];
      ext_g = s[5] & ~UPPER;
      s_int = s[4];
      s_load = s[3] & ~UPPER;
      s_sc = s[2] & ~UPPER;
      s_doc = s[1] & ~UPPER;
      s_coc = s[0] & ~UPPER;
      fmask = UPPER ? ppr_pkg::UPPER_FAULT_MASK : ppr_pkg::LOWER_FAULT_MASK; // see R13
      wake_lvl = ~(s[6] ^ q.regs[7][ppr_pkg::WAKE_POLARITY]); // see R23
      clk_rise = s_clk & ~q.clk_p;
      clk_fall = ~s_clk & q.clk_p;
      nsh = {q.sh[15:0], s_dat};
      d.clk_p = s_clk;
      d.dat_p = s_dat;
      d.wake_p = wake_lvl;
      d.sc_p = s_sc;
      wr_en = 1'b0;
      rd_clr = 1'b0;
      force_rst = 1'b0;
      wa = nsh[15:8];
      wd = nsh[7:0];

      // ---------------------------------------------------------------
      // Read data selection
      // ---------------------------------------------------------------
      rbyte = 8'h00;
      if (nsh[7:0] == ppr_pkg::ADDR_PACK_CONFIG_STATUS) begin
         rbyte[ppr_pkg::UPPER_CASCADE_FLAG] = UPPER;
         rbyte[ppr_pkg::LOWER_CASCADE_FLAG] = ~UPPER;
         rbyte[ppr_pkg::WAKE_PIN_STATE] = wake_lvl; // see R6
      end else if (nsh[7:0] == ppr_pkg::ADDR_FAULT_EVENT_STATUS) begin
         rbyte = {2'b00, q.flags & fmask}; // see R13
      end else if (nsh[7:0] >= ppr_pkg::ADDR_CELL_EQUALIZE_CTRL &&
                   nsh[7:0] <= ppr_pkg::ADDR_WRITE_GUARD_FLAGS) begin
         rbyte = q.regs[nsh[3:0]]; // see R12
      end

      // ---------------------------------------------------------------
      // Frame reception
      // ---------------------------------------------------------------
      case (q.st)
         ppr_pkg::DEV_HEAD: begin
            if (clk_rise) begin
               d.sh = nsh;
               d.cnt = q.cnt + 5'h01;
               if (q.cnt == ppr_pkg::HEAD_BITS - 5'h01) begin
                  d.st = ppr_pkg::DEV_BODY;
                  d.rdm = nsh[8];
                  d.rd = rbyte;
                  rd_clr = nsh[8] && nsh[7:0] == ppr_pkg::ADDR_FAULT_EVENT_STATUS; // see R5
               end
            end
         end
         ppr_pkg::DEV_BODY: begin
            if (clk_rise) begin
               d.sh = nsh;
               d.cnt = q.cnt + 5'h01;
               wr_en = q.cnt == ppr_pkg::FRAME_BITS - 5'h01 && !nsh[16];
            end else if (clk_fall) begin
               if (q.cnt < ppr_pkg::FRAME_BITS) begin
                  d.dat_o = q.rd[7] | ~q.rdm;
                  d.dat_oe_n = ~q.rdm;
                  d.rd = {q.rd[6:0], 1'b0};
               end else begin
                  d.dat_o = 1'b1;
                  d.dat_oe_n = 1'b1;
                  d.st = ppr_pkg::DEV_IDLE;
               end
            end
         end
         default: begin
         end
      endcase
      if (s_clk && q.clk_p && q.dat_p && !s_dat) begin
         d.st = ppr_pkg::DEV_HEAD;
         d.cnt = 5'h00;
         d.dat_o = 1'b1;
         d.dat_oe_n = 1'b1;
      end else if (s_clk && q.clk_p && !q.dat_p && s_dat) begin
         d.st = ppr_pkg::DEV_IDLE;
         d.dat_o = 1'b1;
         d.dat_oe_n = 1'b1;
      end

      // ---------------------------------------------------------------
      // Register writes
      // ---------------------------------------------------------------
      if (wr_en) begin
         if (wa == ppr_pkg::ADDR_DISCHARGE_PROTECT_CFG) begin
            if (q.regs[8][ppr_pkg::DISCHARGE_CFG_WRITE_ENABLE]) begin
               d.regs[5] = wd; // see R16
            end
         end else if (wa == ppr_pkg::ADDR_CHARGE_PROTECT_CFG) begin
            if (q.regs[8][ppr_pkg::CHARGE_CFG_WRITE_ENABLE]) begin
               d.regs[6] = wd; // see R17
            end
         end else if (wa == ppr_pkg::ADDR_FEATURE_OPTIONS) begin
            if (q.regs[8][ppr_pkg::FEATURE_CFG_WRITE_ENABLE]) begin
               d.regs[7] = wd; // see R18
               force_rst = wd[ppr_pkg::FORCE_RESET];
            end
         end else if (wa >= ppr_pkg::ADDR_CELL_EQUALIZE_CTRL &&
                      wa <= ppr_pkg::ADDR_WRITE_GUARD_FLAGS) begin
            d.regs[wa[3:0]] = wd; // see R1, R9, R11, R14
         end
      end

      // ---------------------------------------------------------------
      // Wake clears forced sleep
      // ---------------------------------------------------------------
      if (wake_lvl && !q.wake_p && !q.regs[7][ppr_pkg::WAKE_PIN_OFF]) begin
         d.regs[4][ppr_pkg::FORCE_SLEEP] = 1'b0; // see R8
      end

      // ---------------------------------------------------------------
      // Overcurrent time-outs and automatic shutdown
      // ---------------------------------------------------------------
      dlim = tmo_limit(q.regs[5][ppr_pkg::TIMEOUT_SEL_LSB +: 2],
                       q.regs[6][ppr_pkg::DISCHARGE_TIME_DIV64], ppr_pkg::DIV64_SHIFT); // see R20
      clim = tmo_limit(q.regs[6][ppr_pkg::TIMEOUT_SEL_LSB +: 2],
                       q.regs[6][ppr_pkg::CHARGE_TIME_DIV32], ppr_pkg::DIV32_SHIFT); // see R19
      doc_trip = s_doc && q.dtmr == dlim - 16'h0001;
      coc_trip = s_coc && q.ctmr == clim - 16'h0001;
      sc_trip = s_sc && !q.sc_p;
      d.dtmr = !s_doc ? 16'h0000 : (q.dtmr >= dlim ? q.dtmr : q.dtmr + 16'h0001);
      d.ctmr = !s_coc ? 16'h0000 : (q.ctmr >= clim ? q.ctmr : q.ctmr + 16'h0001);
      kill = (doc_trip && !q.regs[5][ppr_pkg::AUTO_DISCHARGE_OC_OFF]) ||
             (sc_trip && !q.regs[5][ppr_pkg::AUTO_SHORT_OFF]) ||
             (coc_trip && !q.regs[6][ppr_pkg::AUTO_CHARGE_OC_OFF]) ||
             (ext_g && !q.regs[7][ppr_pkg::EXT_THERMAL_SHUTDOWN_OFF]) ||
             (s_int && !q.regs[7][ppr_pkg::INT_THERMAL_SHUTDOWN_OFF]); // see R22
      if (kill) begin
         d.regs[4][ppr_pkg::CHARGE_SWITCH_ENABLE] = 1'b0; // see R10
         d.regs[4][ppr_pkg::DISCHARGE_SWITCH_ENABLE] = 1'b0; // see R10
      end

      // ---------------------------------------------------------------
      // Fault flags, set wins over clear on read
      // ---------------------------------------------------------------
      fset = {ext_g, s_int,
              s_load && q.regs[4][ppr_pkg::MONITOR_CONNECT] &&
              (q.flags[ppr_pkg::DISCHARGE_SHORT_FLAG] ||
               q.flags[ppr_pkg::DISCHARGE_OVERCURRENT_FLAG]),
              sc_trip, doc_trip, coc_trip};
      fcond = {ext_g, s_int, s_load && q.regs[4][ppr_pkg::MONITOR_CONNECT], s_sc, s_doc, s_coc};
      d.flags = (fset | (q.flags & ~({6{rd_clr}} & ~fcond))) & fmask; // see R5

      if (force_rst) begin
         d.regs = '0; // see R24
         d.flags = 6'h00;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0; // see R7, R24
         q.dat_o <= 1'b1;
         q.dat_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign link.dev_dat_o = q.dat_o;
   assign link.dev_dat_oe_n = q.dat_oe_n;
   assign charge_drive = q.regs[4][ppr_pkg::CHARGE_SWITCH_ENABLE]; // see R11
   assign discharge_drive = q.regs[4][ppr_pkg::DISCHARGE_SWITCH_ENABLE];
   assign sleep_req = q.regs[4][ppr_pkg::FORCE_SLEEP];
   assign monitor_connect = q.regs[4][ppr_pkg::MONITOR_CONNECT];
   assign cell_equalize = q.regs[2][7:1];
   assign monitor_select = q.regs[3][3:0];
   assign ext_temp_scan_off = q.regs[7][ppr_pkg::EXT_TEMP_SCAN_OFF]; // see R21
endmodule // ppr_device

/* ppr_host.sv */
/*
 Controller end: AHB-Lite slave with a command and a status register,
 and the frame generator that makes the link clock. Assumes the register
 bank answers reads on the falling link clock edge.
*/
module ppr_host #(
   parameter logic [7:0] HALF = ppr_pkg::LINK_HALF_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link
   ppr_link_if.host link
);
   typedef struct packed {
      ppr_pkg::ppr_host_state_type st;
      logic [8:0] cnt;
      logic [4:0] bitn;
      logic [16:0] sh;
      logic rdm;
      logic [7:0] rd;
      logic [7:0] rdata;
      logic [16:0] cmd;
      logic busy;
      logic lclk;
      logic dat_o;
      logic dat_oe_n;
      logic wpend;
      logic wcmd;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } ppr_host_q_type;

   ppr_host_q_type q;
   ppr_host_q_type d;
   logic s_dat;

   ppr_sync #(.WIDTH(1)) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in(link.dat),
      .sync_out(s_dat)
   );

   always_comb begin
      d = q;
      d.cnt = q.cnt + 9'h001;

      // ---------------------------------------------------------------
      // Bus slave
      // ---------------------------------------------------------------
      d.wpend = 1'b0;
      if (hsel && htrans[1] && hready) begin
         d.wpend = hwrite;
         d.wcmd = haddr[7:0] == ppr_pkg::HOST_CMD_OFS;
         d.hrdata = 32'h0000_0000;
         if (!hwrite && haddr[7:0] == ppr_pkg::HOST_CMD_OFS) begin
            d.hrdata = {15'h0000, q.cmd};
         end else if (!hwrite && haddr[7:0] == ppr_pkg::HOST_STATUS_OFS) begin
            d.hrdata = {23'h00_0000, q.busy, q.rdata};
         end
      end

      // ---------------------------------------------------------------
      // Frame generator
      // ---------------------------------------------------------------
      case (q.st)
         ppr_pkg::HOST_IDLE: begin
            d.lclk = 1'b1;
            if (q.wpend && q.wcmd) begin
               d.cmd = hwdata[16:0];
               d.sh = hwdata[16:0];
               d.rdm = hwdata[ppr_pkg::CMD_READ_BIT];
               d.busy = 1'b1;
               d.st = ppr_pkg::HOST_START;
               d.cnt = 9'h000;
               d.dat_o = 1'b0;
               d.dat_oe_n = 1'b0;
            end
         end
         ppr_pkg::HOST_START: begin
            if (q.cnt == {1'b0, HALF - 8'h01}) begin
               d.lclk = 1'b0;
               d.st = ppr_pkg::HOST_LOW;
               d.cnt = 9'h000;
               d.bitn = 5'h00;
            end
         end
         ppr_pkg::HOST_LOW: begin
            if (q.cnt == 9'h001) begin
               if (q.bitn < ppr_pkg::HEAD_BITS || !q.rdm) begin
                  d.dat_o = q.sh[16]; // see R2, R15
                  d.dat_oe_n = 1'b0;
                  d.sh = {q.sh[15:0], 1'b0};
               end else begin
                  d.dat_o = 1'b1;
                  d.dat_oe_n = 1'b1;
               end
            end
            if (q.cnt == {1'b0, HALF - 8'h01}) begin
               if (q.rdm && q.bitn >= ppr_pkg::HEAD_BITS) begin
                  d.rd = {q.rd[6:0], s_dat};
               end
               d.lclk = 1'b1;
               d.st = ppr_pkg::HOST_HIGH;
               d.cnt = 9'h000;
            end
         end
         ppr_pkg::HOST_HIGH: begin
            if (q.cnt == {1'b0, HALF - 8'h01}) begin
               d.lclk = 1'b0;
               d.cnt = 9'h000;
               d.bitn = q.bitn + 5'h01;
               d.st = q.bitn == ppr_pkg::FRAME_BITS - 5'h01 ? ppr_pkg::HOST_STOP
                                                              : ppr_pkg::HOST_LOW;
            end
         end
         ppr_pkg::HOST_STOP: begin
            if (q.cnt == 9'h004) begin
               d.dat_o = 1'b0;
               d.dat_oe_n = 1'b0;
            end
            if (q.cnt == {1'b0, HALF - 8'h01}) begin
               d.lclk = 1'b1;
            end
            if (q.cnt == {HALF, 1'b0} - 9'h001) begin
               d.dat_o = 1'b1;
               d.dat_oe_n = 1'b1;
               d.busy = 1'b0;
               d.rdata = q.rdm ? q.rd : q.rdata; // see R4
               d.st = ppr_pkg::HOST_IDLE;
            end
         end
         default: begin
            d.st = ppr_pkg::HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.lclk <= 1'b1;
         q.dat_o <= 1'b1;
         q.dat_oe_n <= 1'b1;
         q.hreadyout <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = q.hresp;
   assign link.link_clk = q.lclk;
   assign link.host_dat_o = q.dat_o;
   assign link.host_dat_oe_n = q.dat_oe_n;
endmodule // ppr_host

/* ppr_link_sva.sv */
/* Checks on the two-wire link between controller and register bank.
   Assumes both ends run on one core clock and share one reset. */
module ppr_link_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Link wires
   input wire logic link_clk,
   input wire logic host_dat_o,
   input wire logic host_dat_oe_n,
   input wire logic dev_dat_o,
   input wire logic dev_dat_oe_n,
   input wire logic dat
);
   // ---------------------------------------------------------------
   // Wire checks
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_no_clash; host_dat_oe_n || dev_dat_oe_n; endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive");
   property p_half; $changed(link_clk) |=> $stable(link_clk) [*7]; endproperty
   a_half: assert property (p_half) else $error("short link half");
   property p_dev_hold; link_clk && $past(link_clk) |-> $stable(dev_dat_oe_n)
      && (dev_dat_oe_n || $stable(dev_dat_o)); endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("reply moved in high");
   property p_dev_take; $fell(dev_dat_oe_n) |-> host_dat_oe_n && !link_clk; endproperty
   a_dev_take: assert property (p_dev_take) else $error("bad reply start");
   property p_dev_rel; $rose(dev_dat_oe_n) |-> !link_clk; endproperty
   a_dev_rel: assert property (p_dev_rel) else $error("bad reply end");
   property p_start; $fell(host_dat_oe_n) && link_clk |-> !host_dat_o; endproperty
   a_start: assert property (p_start) else $error("start not low");
   property p_frame; $fell(host_dat_oe_n) && link_clk
      |-> ##[250:330] ($rose(dat) && link_clk); endproperty
   a_frame: assert property (p_frame) else $error("frame length");
   property p_stop; $rose(dat) && link_clk |=> dat [*2]; endproperty
   a_stop: assert property (p_stop) else $error("line not idle");
endmodule // ppr_link_sva

/* test_pack_protect_register_bank.sv */
/* Bench for both ends of the register bank link.
   Assumes the package, interface and both end modules are compiled first. */
module test_pack_protect_register_bank;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, resetn = 0, hsel = 0, hwrite = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rdat;
   logic hreadyout, hresp, wake = 0, shrt = 0, ihot = 0, chg, dis, slp, mon, scan;
   logic [6:0] eq;
   logic [3:0] msel;
   logic [7:0] b, v, a8;
   logic [7:0] r [2:4] = '{default: 8'h00};
   int error_cnt = 0, n_checks = 0, seed = 91;
   ppr_link_if link ();
   always #25 core_clk = ~core_clk;
   ppr_host u_ppr_host (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
   ppr_device #(.UPPER(1'b0), .TIMEOUT_BASE(16'h0040)) u_ppr_device (.core_clk(core_clk),
      .resetn(resetn), .link(link), .wake_cmp(wake), .ext_hot(shrt), .int_hot(ihot),
      .load_heavy(1'b0), .short_cond(shrt), .dis_oc_cond(ihot), .chg_oc_cond(1'b0),
      .charge_drive(chg), .discharge_drive(dis), .sleep_req(slp), .monitor_connect(mon),
      .cell_equalize(eq), .monitor_select(msel), .ext_temp_scan_off(scan));
   ppr_link_sva u_ppr_link_sva (.core_clk(core_clk), .resetn(resetn),
      .link_clk(link.link_clk), .host_dat_o(link.host_dat_o),
      .host_dat_oe_n(link.host_dat_oe_n), .dev_dat_o(link.dev_dat_o),
      .dev_dat_oe_n(link.dev_dat_oe_n), .dat(link.dat));
   // ---------------------------------------------------------------
   // Tasks and expectations
   // ---------------------------------------------------------------
   function automatic logic [7:0] cfg_exp(input logic pol, input logic w);
      return {3'h2, ~(w ^ pol), 4'h0};
   endfunction
   function automatic logic [7:0] rmask(input logic [7:0] a);
      return a == 8'h02 ? 8'hfe : a == 8'h03 ? 8'hcf : 8'hc3;
   endfunction
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      chk({7'h00, hresp}, 8'h00);
   endtask
   task automatic cmd(input logic rw, input logic [7:0] a, input logic [7:0] d);
      ahb(1'b1, 32'h0000_0000, {15'h0000, rw, a, d});
      for (int i = 0; i < 400; i++) begin
         ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
         if (rdat[8] === 1'b0) break;
      end
      chk(rdat[15:8], 8'h00);
      b = rdat[7:0];
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cmd(1'b1, a, 8'h00);
      chk(b, e);
   endtask
   initial begin
      #3000000;
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(8'h00, cfg_exp(1'b0, 1'b0));
      for (int a = 1; a < 9; a++) rd(a[7:0], 8'h00);
      for (int i = 0; i < 12; i++) begin
         a8 = 8'h02 + 8'(i % 3);
         v = 8'($random(seed)) & rmask(a8);
         r[a8] = v;
         cmd(1'b0, a8, v);
         rd(a8, v);
         chk({eq, 1'b0}, r[2]);
         chk({4'h0, msel}, r[3] & 8'h0f);
         chk({slp, mon, 4'h0, chg, dis}, r[4]);
      end
      for (int a = 5; a < 8; a++) begin
         cmd(1'b0, a[7:0], 8'h18);
         rd(a[7:0], 8'h00);
      end
      cmd(1'b0, 8'h08, 8'he0);
      cmd(1'b0, 8'h05, 8'h00);
      cmd(1'b0, 8'h06, 8'h0c);
      rd(8'h06, 8'h0c);
      cmd(1'b0, 8'h07, 8'h81);
      rd(8'h07, 8'h81);
      chk({7'h00, scan}, 8'h01);
      rd(8'h00, cfg_exp(1'b1, 1'b0));
      wake <= 1'b1;
      rd(8'h00, cfg_exp(1'b1, 1'b1));
      rd(8'h00, cfg_exp(1'b1, 1'b1));
      wake <= 1'b0;
      cmd(1'b0, 8'h04, 8'h83);
      chk({7'h00, slp}, 8'h01);
      wake <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk({7'h00, slp}, 8'h00);
      rd(8'h04, 8'h03);
      shrt <= 1'b1;
      ihot <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk({6'h00, chg, dis}, 8'h00);
      rd(8'h04, 8'h00);
      shrt <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd(8'h01, 8'h36);
      rd(8'h01, 8'h12);
      ihot <= 1'b0;
      repeat (5) @(posedge core_clk);
      rd(8'h01, 8'h12);
      rd(8'h01, 8'h00);
      close_out();
   end
endmodule // test_pack_protect_register_bank
